// [hdl/adc_door_ctrl.sv]
`timescale 1ns/1ps

module adc_door_ctrl import adc_pkg::*; #(
    parameter logic [TMR_W-1:0] CLEAR_CYCLES = CLEAR_TICKS,
    parameter logic [TMR_W-1:0] EXIT_CYCLES = EXIT_TICKS,
    parameter logic [TMR_W-1:0] BUZZ_CYCLES = BUZZ_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_outside_motion_sensor,
    input wire logic i_inside_motion_sensor,
    input wire logic i_open_limit_input,
    input wire logic i_closed_limit_input,
    input wire logic i_force_open_input,
    input wire logic i_force_close_input,
    input wire logic i_business_hours,
    output logic o_open_drive_output,
    output logic o_close_drive_output,
    output logic o_warning_buzzer_output
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    adc_state_type state_q;
    adc_state_type state_d;
    logic any_motion;
    logic exit_busy;
    logic clear_busy;
    logic buzz_busy;
    logic exit_en;
    logic open_req;
    logic clear_ok;
    logic close_start;

    // ------------------------------------------------------------------
    // Timers.
    // ------------------------------------------------------------------
    // The exit window is reloaded all through business hours, so it runs
    // out one window length after they end.
    adc_countdown #(
        .LOAD(EXIT_CYCLES)
    ) u_exit_tmr (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_load(i_business_hours),
        .o_busy(exit_busy)
    );

    // The clear timer is reloaded by any presence, so it only expires
    // after an unbroken stretch of empty doorway.
    adc_countdown #(
        .LOAD(CLEAR_CYCLES)
    ) u_clear_tmr (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_load(any_motion),
        .o_busy(clear_busy)
    );

    // The buzzer timer is loaded once when the close motor starts.
    adc_countdown #(
        .LOAD(BUZZ_CYCLES)
    ) u_buzz_tmr (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_load(close_start),
        .o_busy(buzz_busy)
    );

    // ------------------------------------------------------------------
    // Motion qualification.
    // ------------------------------------------------------------------
    // Raw presence keeps the door from closing whatever the hour.
    assign any_motion = i_outside_motion_sensor | i_inside_motion_sensor;
    // Inside sensor stays live for the exit window after hours.
    assign exit_en = i_business_hours | exit_busy;
    // Outside only counts in business hours, inside within the window.
    assign open_req = (i_outside_motion_sensor & i_business_hours)
        | (i_inside_motion_sensor & exit_en);
    // Doorway empty now and for the whole clear delay.
    assign clear_ok = ~any_motion & ~clear_busy;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // Selector closed position masks sensor opening; open position wins
    // over everything so nobody is trapped.
    always_comb begin
        state_d = state_q;
        state_d.open_drive = (i_force_open_input
            | (open_req & ~i_force_close_input))
            & ~i_open_limit_input;
        state_d.close_drive = (i_force_close_input | clear_ok)
            & ~any_motion
            & ~i_closed_limit_input
            & ~i_force_open_input
            & ~state_d.open_drive;
        // The close start is rebuilt here so this process never reads a
        // net that is itself derived from its own output.
        state_d.buzzer = (state_d.close_drive & ~state_q.close_drive)
            | buzz_busy;
    end

    // A new close command starts the warning pulse.
    assign close_start = state_d.close_drive & ~state_q.close_drive;

    // ------------------------------------------------------------------
    // State register and outputs.
    // ------------------------------------------------------------------
    // All outputs come straight from this register.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_open_drive_output = state_q.open_drive;
    assign o_close_drive_output = state_q.close_drive;
    assign o_warning_buzzer_output = state_q.buzzer;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    // Counts the cycles of the current buzzer pulse. A new close start
    // restarts the count, and the last length is held after it falls.
    logic [TMR_W-1:0] buzz_len_q;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            buzz_len_q <= CNT_RESET;
        end else if (close_start) begin
            buzz_len_q <= TMR_W'(1);
        end else if (state_d.buzzer) begin
            buzz_len_q <= buzz_len_q + TMR_W'(1);
        end
    end

    // Both motors are never driven together.
    a_motor_exclusive: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        !(o_open_drive_output && o_close_drive_output))
        else $error("Open and close motors driven together.");

    // Force-open drives the door open until the open limit.
    a_force_open: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_force_open_input && !i_open_limit_input)
        |=> o_open_drive_output)
        else $error("Force-open did not start the open motor.");

    // Each limit switch stops its own motor on the next edge.
    a_limit_stops: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_open_limit_input |=> !o_open_drive_output)
        and (i_closed_limit_input |=> !o_close_drive_output))
        else $error("Motor still driven at its limit.");

    // Presence in the doorway blocks any close command.
    a_no_close_busy: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_outside_motion_sensor || i_inside_motion_sensor)
        |=> !o_close_drive_output)
        else $error("Close commanded with someone in the doorway.");

    // Outside sensor opens the door during business hours.
    a_outside_opens: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_outside_motion_sensor && i_business_hours
            && !i_open_limit_input && !i_force_close_input)
        |=> o_open_drive_output)
        else $error("Outside motion in hours did not open the door.");

    // Inside sensor opens the door during business hours.
    a_inside_opens: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_inside_motion_sensor && i_business_hours
            && !i_open_limit_input && !i_force_close_input)
        |=> o_open_drive_output)
        else $error("Inside motion did not open the door.");

    // After hours the outside sensor alone never opens the door.
    a_outside_ignored: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_outside_motion_sensor && !i_inside_motion_sensor
            && !i_business_hours && !i_force_open_input)
        |=> !o_open_drive_output)
        else $error("Outside motion opened the door after hours.");

    // Closing by sensors needs a clear doorway on the prior edge.
    a_close_after_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ($rose(o_close_drive_output) && !$past(i_force_close_input))
        |-> $past(!any_motion && !clear_busy))
        else $error("Sensor close started before the clear delay.");

    // Selector closed position closes an empty doorway at once.
    a_force_close: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_force_close_input && !i_force_open_input && !any_motion
            && !i_closed_limit_input)
        |=> o_close_drive_output)
        else $error("Force-close did not start the close motor.");

    // The buzzer starts with the close motor and lasts exactly its time.
    a_buzz_pulse: assert property (
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        ($rose(o_close_drive_output)
            |-> (o_warning_buzzer_output && buzz_len_q == TMR_W'(1)))
        and ($fell(o_warning_buzzer_output)
            |-> buzz_len_q == BUZZ_CYCLES))
        else $error("Buzzer pulse start or length wrong.");

endmodule : adc_door_ctrl

// [hdl/adc_pkg.sv]
package adc_pkg;

    // ------------------------------------------------------------------
    // Clock and timer widths.
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned TMR_W = 40;

    // ------------------------------------------------------------------
    // Times in their own units and their derived tick counts.
    // ------------------------------------------------------------------
    // Warning buzzer pulse when closing begins.
    localparam longint unsigned BUZZ_TIME_MS = 1000;
    // Inside sensor stays honoured this long after business hours end.
    localparam longint unsigned EXIT_TIME_S = 3600;
    // Doorway must read clear this long before a sensor close may start; the selector closed position does not wait for it.
    localparam longint unsigned CLEAR_TIME_MS = 2000;

    localparam logic [TMR_W-1:0] BUZZ_TICKS =
        TMR_W'(BUZZ_TIME_MS * CLK_FREQ_HZ / 1000);
    localparam logic [TMR_W-1:0] EXIT_TICKS =
        TMR_W'(EXIT_TIME_S * CLK_FREQ_HZ);
    localparam logic [TMR_W-1:0] CLEAR_TICKS =
        TMR_W'(CLEAR_TIME_MS * CLK_FREQ_HZ / 1000);

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [TMR_W-1:0] CNT_RESET = 40'h00_0000_0000;

    // ------------------------------------------------------------------
    // State carriers.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [TMR_W-1:0] count;
    } adc_cnt_type;

    typedef struct packed {
        logic open_drive;
        logic close_drive;
        logic buzzer;
    } adc_state_type;

    localparam adc_state_type STATE_RESET = '{
        open_drive: 1'b0,
        close_drive: 1'b0,
        buzzer: 1'b0
    };

endpackage : adc_pkg

// [hdl/adc_countdown.sv]
`timescale 1ns/1ps

// Retriggerable countdown: a load holds it busy for LOAD-1 cycles after
// the last load.
module adc_countdown import adc_pkg::*; #(
    parameter logic [TMR_W-1:0] LOAD = CLEAR_TICKS
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_load,
    output logic o_busy
);

    adc_cnt_type cnt_q;
    adc_cnt_type cnt_d;

    // Reload on request, otherwise count down to zero and stop there.
    always_comb begin
        cnt_d = cnt_q;
        if (i_load) begin
            cnt_d.count = TMR_W'(LOAD - TMR_W'(1));
        end else if (cnt_q.count != CNT_RESET) begin
            cnt_d.count = cnt_q.count - TMR_W'(1);
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q.count <= CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Busy while any count remains.
    assign o_busy = (cnt_q.count != CNT_RESET);

endmodule : adc_countdown

// [tb/adc_door_mech.sv]
`timescale 1ns/1ps

// Door mechanics seen from the controller: the motors move the leaf one
// step per cycle and the two limit switches report the end positions.
module adc_door_mech #(
    parameter int TRAVEL = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_open_drive,
    input wire logic i_close_drive,
    output logic o_open_limit,
    output logic o_closed_limit
);
    int pos_q;

    // The leaf moves while a motor runs and stops at either end stop.
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pos_q <= 0;
        end else if (i_open_drive && pos_q < TRAVEL) begin
            pos_q <= pos_q + 1;
        end else if (i_close_drive && pos_q > 0) begin
            pos_q <= pos_q - 1;
        end
    end

    // Limit switches are levels taken from the leaf position.
    assign o_open_limit = (pos_q == TRAVEL);
    assign o_closed_limit = (pos_q == 0);
endmodule : adc_door_mech

// [tb/adc_door_ctrl_test.sv]
`timescale 1ns/1ps

module adc_door_ctrl_test;
    import adc_pkg::*;
    localparam logic [TMR_W-1:0] CLR_N = 40'h00_0000_0008;
    localparam logic [TMR_W-1:0] EXIT_N = 40'h00_0000_0032;
    localparam logic [TMR_W-1:0] BUZZ_N = 40'h00_0000_0005;
    logic clk, rst_n, outs, ins, fo, fc, hours, olim, clim;
    logic o_open, o_close, o_buzz, mot, req, od, cd, bz_prev;
    logic opn_q, cls_q;
    logic [TMR_W-1:0] clr_q, ext_q, bz_q;
    logic [2:0] exp_q[$];
    logic [2:0] e;
    logic [31:0] lfsr;
    int bad_count, n_tests, n_buzz;

    adc_door_ctrl #(.CLEAR_CYCLES(CLR_N), .EXIT_CYCLES(EXIT_N),
        .BUZZ_CYCLES(BUZZ_N)) adc_door_ctrl_inst (
        .i_clk_sys(clk), .i_arst_n(rst_n),
        .i_outside_motion_sensor(outs), .i_inside_motion_sensor(ins),
        .i_open_limit_input(olim), .i_closed_limit_input(clim),
        .i_force_open_input(fo), .i_force_close_input(fc),
        .i_business_hours(hours), .o_open_drive_output(o_open),
        .o_close_drive_output(o_close), .o_warning_buzzer_output(o_buzz));

    adc_door_mech adc_door_mech_inst (
        .i_clk_sys(clk), .i_arst_n(rst_n), .i_open_drive(o_open),
        .i_close_drive(o_close), .o_open_limit(olim),
        .o_closed_limit(clim));

    // Galois shift register for the random stimulus.
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction : lfsr_next

    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        n_tests++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic final_report();
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Reference equations, taken from the inputs before each edge.
    assign mot = outs | ins;
    assign req = (outs & hours) | (ins & (hours | (ext_q != 0)));
    assign od = (fo | (req & !fc)) & !olim;
    assign cd = (fc | (clr_q == 0)) & !mot & !clim & !fo & !od;

    // Reference timers; each edge leaves one expected output note.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {opn_q, cls_q} <= 2'b00;
            clr_q <= '0;
            ext_q <= '0;
            bz_q <= '0;
            exp_q.delete();
        end else begin
            opn_q <= od;
            cls_q <= cd;
            clr_q <= mot ? CLR_N - 1 : (clr_q != 0 ? clr_q - 1 : clr_q);
            ext_q <= hours ? EXIT_N - 1 : (ext_q != 0 ? ext_q - 1 : ext_q);
            bz_q <= (cd & !cls_q) ? BUZZ_N : (bz_q != 0 ? bz_q - 1 : bz_q);
            exp_q.push_back({od, cd, (cd & !cls_q) | (bz_q > 1)});
        end
    end

    // Output watcher: compares each cycle's outputs with the oldest note.
    always @(negedge clk) begin
        if (!rst_n) begin
            check(40'({o_open, o_close, o_buzz}), 40'h00_0000_0000);
        end else if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(40'(o_open), 40'(e[2]));
            check(40'(o_close), 40'(e[1]));
            check(40'(o_buzz), 40'(e[0]));
        end
        n_buzz += (o_buzz === 1'b1 && bz_prev === 1'b0) ? 1 : 0;
        bz_prev = o_buzz;
    end

    // Clock generation.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Stimulus: random presence, hour blocks and selector modes.
    initial begin
        rst_n = 1'b0;
        {outs, ins, fo, fc, hours, bz_prev} = 6'b00_0000;
        lfsr = 32'h0000_2608;
        bad_count = 0;
        n_tests = 0;
        n_buzz = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6000; i++) begin
            @(posedge clk);
            lfsr = lfsr_next(lfsr);
            if (lfsr[2:0] == 3'h0) begin
                outs <= (lfsr[5:3] == 3'h0);
                ins <= (lfsr[8:6] == 3'h0);
            end
            hours <= (((i >> 7) & 3) != 0);
            fo <= ((i >> 9) % 4 == 1) || ((i >> 9) % 4 == 3 && lfsr[20]);
            fc <= ((i >> 9) % 4 >= 2);
            if (i == 3000) begin
                rst_n <= 1'b0;
            end
            if (i == 3003) begin
                rst_n <= 1'b1;
            end
        end
        @(negedge clk);
        check(40'(n_buzz != 0), 40'h00_0000_0001);
        final_report();
    end
endmodule : adc_door_ctrl_test
